//--- design/cidf_pkg.sv
// Package with constants and carrier types for the identifier filter and port block
// Functional notes
// - Compare code bits with same-position identifier bits
// - Qualify each compare result with its mask bit
// - Mask 0: bits must equal; all must match
// - Mask 1: bit position is don't-care
// - Code and mask writes only during soft reset
// - Port control covers pins 7..2 only
// - Pull-up enable bit switches pull devices
// - Reduced-drive bit selects reduced output strength
// - Data write stores latch; driven when output
// - Data read: latch if output, pin if input
// - Bits 1,0 read link pins; writes ignored
// - Direction 1 is output, 0 is input
// - In 2x32 mode extended uses four byte pairs, standard two
// - Mode field: 2x32, 4x16, 8x8, closed
package cidf_pkg;

	// Bus widths
	localparam int WB_AW = 12;
	localparam int WB_DW = 32;
	localparam int IDX_W = 10;

	// Register word indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CODE [8] = '{10'h110, 10'h111, 10'h112, 10'h113,
		10'h118, 10'h119, 10'h11A, 10'h11B};
	localparam logic [IDX_W-1:0] IDX_MASK [8] = '{10'h114, 10'h115, 10'h116, 10'h117,
		10'h11C, 10'h11D, 10'h11E, 10'h11F};
	localparam logic [IDX_W-1:0] IDX_CTL0 = 10'h120;
	localparam logic [IDX_W-1:0] IDX_MODE = 10'h108;
	localparam logic [IDX_W-1:0] IDX_PCTL = 10'h13D;
	localparam logic [IDX_W-1:0] IDX_PDAT = 10'h13E;
	localparam logic [IDX_W-1:0] IDX_PDIR = 10'h13F;

	// Field positions
	localparam int SOFT_RESET_BIT = 0;
	localparam int MODE_LSB       = 4;
	localparam int PUP_BIT        = 1;
	localparam int RDP_BIT        = 0;
	localparam int TX_BIT         = 1;
	localparam int RX_BIT         = 0;

	// Values after reset
	localparam logic [7:0] CODE_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic       SRST_RST = 1'b1;
	localparam logic [7:0] PCTL_RST = 8'h00;
	localparam logic [7:0] PDAT_RST = 8'h00;
	localparam logic [7:0] PDIR_RST = 8'h00;

	// Filter organisation
	typedef enum logic [1:0] {
		CIDF_ORG_32  = 2'h0,
		CIDF_ORG_16  = 2'h1,
		CIDF_ORG_8   = 2'h2,
		CIDF_ORG_OFF = 2'h3
	} cidf_org_e;

	// Wishbone request from the master
	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [WB_AW-1:0] adr;
		logic [3:0]       sel;
		logic [WB_DW-1:0] dat;
	} cidf_wb_req_s;

	// Identifier of a received message, byte 0 first
	typedef struct packed {
		logic            valid;
		logic            ext;
		logic [3:0][7:0] id;
	} cidf_msg_s;

	// Acceptance verdict
	typedef struct packed {
		logic       valid;
		logic       hit;
		logic [2:0] idx;
	} cidf_acc_s;

endpackage

//--- design/cidf_top.sv
// Identifier acceptance filter, port pin I/O and their Wishbone register slave
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
module cidf_top (
	// Clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  reset_i,
	// Wishbone slave
	input  wire cidf_pkg::cidf_wb_req_s wb_req_i,
	output logic                       wb_ack_o,
	output logic [cidf_pkg::WB_DW-1:0] wb_dat_o,
	// Received message and verdict
	input  wire cidf_pkg::cidf_msg_s   msg_i,
	output cidf_pkg::cidf_acc_s        acc_o,
	// Link pins, sensed only
	input  wire logic                  link_transmit_pin_i,
	input  wire logic                  link_receive_pin_i,
	// General purpose port pins 7..2
	input  wire logic [7:2]            port_pin_i,
	output logic [7:2]                 port_pin_o,
	output logic [7:2]                 port_pin_oe_n_o,
	output logic                       port_pullup_enable_o,
	output logic                       port_reduced_drive_o
);
	import cidf_pkg::*;

	// Byte-wise match with mask as don't-care
	// A set mask bit forces its position true, so only unmasked bits must agree
	// The reduction AND then demands that every unmasked position agrees
	// Used for all eight code bytes, hence a function rather than copied logic
	function automatic logic byte_match(input logic [7:0] code, input logic [7:0] mask,
		input logic [7:0] id);
		byte_match = &(~(code ^ id) | mask);
	endfunction

	// Register state
	// Code and mask bytes keep whatever software last wrote in soft reset; reset clears them
	// only so that a filter never compares against unknown bits
	logic [7:0] code_r [8];       // Acceptance code registers
	logic [7:0] code_nxt [8];
	logic [7:0] mask_r [8];       // Acceptance mask registers
	logic [7:0] mask_nxt [8];
	logic       srst_r;           // Soft reset bit
	logic       srst_nxt;
	cidf_org_e  org_r;            // Filter organisation field
	cidf_org_e  org_nxt;
	logic [2:0] hit_idx_r;        // Last hit filter, readable
	logic [2:0] hit_idx_nxt;
	logic [7:0] pctl_r;           // Pull-up and drive control
	logic [7:0] pctl_nxt;
	logic [7:2] pdat_r;           // Port data latches
	logic [7:2] pdat_nxt;
	logic [7:2] pdir_r;           // Port directions
	logic [7:2] pdir_nxt;
	logic [7:2] oe_n_nxt;

	// Bus answer
	// Ack and read data are registered: one wait state is traded for outputs
	// that come straight from flops
	logic              ack_nxt;
	logic [WB_DW-1:0]  dat_nxt;
	cidf_acc_s         acc_nxt;

	// Pin synchronisers
	// Pins are asynchronous to the bus clock; two stages keep a metastable
	// level away from the read path, so a pin change shows up in a read
	// only two clocks later
	logic [7:2] gp_meta_r;
	logic [7:2] gp_sync_r;
	logic       tx_meta_r;
	logic       tx_sync_r;
	logic       rx_meta_r;
	logic       rx_sync_r;

	// Decoded request
	// A request is taken only while ack is low, so a strobe that is held
	// through the ack cycle is not taken twice in a row
	// Only byte lane 0 carries register data; other lanes are ignored
	logic             req;
	logic             wr;
	logic [IDX_W-1:0] idx;
	logic [7:0]       wbyte;

	assign req   = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
	assign wr    = req & wb_req_i.we & wb_req_i.sel[0];
	assign idx   = wb_req_i.adr[WB_AW-1:2];
	assign wbyte = wb_req_i.dat[7:0];

	// Two flip-flop synchronisers; only the second stage is read
	// No reset: the chain flushes within two clocks anyway
	always_ff @(posedge sys_clk_i) begin
		gp_meta_r <= port_pin_i;
		gp_sync_r <= gp_meta_r;
		tx_meta_r <= link_transmit_pin_i;
		tx_sync_r <= tx_meta_r;
		rx_meta_r <= link_receive_pin_i;
		rx_sync_r <= rx_meta_r;
	end

	// Per code byte match; the identifier byte compared depends on organisation
	// 32-bit filters walk all four identifier bytes, 16-bit filters the
	// first two, 8-bit filters only the first one
	logic [7:0] bm;
	generate
		for (genvar k = 0; k < 8; k++) begin : g_byte
			logic [7:0] idb;
			always_comb begin
				unique case (org_r)
					CIDF_ORG_32: idb = msg_i.id[k % 4];
					CIDF_ORG_16: idb = msg_i.id[k % 2];
					default:     idb = msg_i.id[0];
				endcase
			end
			assign bm[k] = byte_match(code_r[k], mask_r[k], idb);
		end
	endgenerate

	// Filter hits for the selected organisation
	// Each filter is the AND of the byte matches its identifier type uses; a closed bank reports
	// no hit at all, yet the verdict is still issued
	logic [7:0] fhit;
	always_comb begin
		fhit = 8'h00;
		unique case (org_r)
			CIDF_ORG_32: begin
				for (int f = 0; f < 2; f++) begin
					// Standard identifiers use only the first two pairs
					fhit[f] = bm[4*f] & bm[4*f+1] & (~msg_i.ext | (bm[4*f+2] & bm[4*f+3]));
				end
			end
			CIDF_ORG_16: begin
				for (int f = 0; f < 4; f++) begin
					fhit[f] = bm[2*f] & bm[2*f+1];
				end
			end
			CIDF_ORG_8: begin
				fhit = bm;
			end
			CIDF_ORG_OFF: begin
				// Closed: nothing is accepted
				fhit = 8'h00;
			end
		endcase
	end

	// Verdict: lowest numbered filter wins; no verdict while held in soft reset
	// The loop runs downwards so the last assignment is the lowest hit
	// The hit index holds its value when no filter matches, so software
	// still sees the filter of the last accepted message
	always_comb begin
		acc_nxt       = '0;
		hit_idx_nxt   = hit_idx_r;
		acc_nxt.valid = msg_i.valid & ~srst_r;
		acc_nxt.hit   = |fhit;
		for (int f = 7; f >= 0; f--) begin
			if (fhit[f]) begin
				acc_nxt.idx = f[2:0];
			end
		end
		if (acc_nxt.valid && acc_nxt.hit) begin
			hit_idx_nxt = acc_nxt.idx;
		end
	end

	// Register writes
	// Filter code, mask and organisation are frozen outside soft reset so
	// that the filters never change under a message being checked
	// The soft reset bit itself is always writable, otherwise software
	// could never leave or re-enter setup
	always_comb begin
		code_nxt = code_r;
		mask_nxt = mask_r;
		srst_nxt = srst_r;
		org_nxt  = org_r;
		pctl_nxt = pctl_r;
		pdat_nxt = pdat_r;
		pdir_nxt = pdir_r;
		if (wr) begin
			for (int k = 0; k < 8; k++) begin
				// Filter setup is frozen outside soft reset
				if (idx == IDX_CODE[k] && srst_r) begin
					code_nxt[k] = wbyte;
				end
				if (idx == IDX_MASK[k] && srst_r) begin
					mask_nxt[k] = wbyte;
				end
			end
			if (idx == IDX_MODE && srst_r) begin
				// Hit index bits of this word are read only
				org_nxt = cidf_org_e'(wbyte[MODE_LSB+:2]);
			end
			if (idx == IDX_CTL0) begin
				// Leaving soft reset starts acceptance with the next message
				srst_nxt = wbyte[SOFT_RESET_BIT];
			end
			if (idx == IDX_PCTL) begin
				// Only two control bits exist; the rest stay zero
				pctl_nxt = '0;
				pctl_nxt[PUP_BIT] = wbyte[PUP_BIT];
				pctl_nxt[RDP_BIT] = wbyte[RDP_BIT];
			end
			if (idx == IDX_PDAT) begin
				// Bits 1 and 0 have no storage, so writes to them vanish
				pdat_nxt = wbyte[7:2];
			end
			if (idx == IDX_PDIR) begin
				pdir_nxt = wbyte[7:2];
			end
		end
		oe_n_nxt = ~pdir_nxt;
	end

	// Read data and acknowledge, one wait state, unmapped reads return zero
	// Data is driven only in the ack cycle and is zero otherwise, so a
	// master that samples late sees zero rather than stale data
	always_comb begin
		dat_nxt = '0;
		ack_nxt = req;
		if (req && !wb_req_i.we) begin
			for (int k = 0; k < 8; k++) begin
				if (idx == IDX_CODE[k]) begin
					dat_nxt[7:0] = code_r[k];
				end
				if (idx == IDX_MASK[k]) begin
					dat_nxt[7:0] = mask_r[k];
				end
			end
			unique case (idx)
				IDX_MODE: begin
					// Organisation and last hit share one word
					dat_nxt[MODE_LSB+:2] = org_r;
					dat_nxt[2:0]         = hit_idx_r;
				end
				IDX_CTL0: begin
					dat_nxt[SOFT_RESET_BIT] = srst_r;
				end
				IDX_PCTL: begin
					dat_nxt[7:0] = pctl_r;
				end
				IDX_PDAT: begin
					// Outputs read back the latch, inputs the pin
					// Reading the latch for outputs means a loaded pin cannot
					// change what software reads back
					for (int i = 2; i < 8; i++) begin
						dat_nxt[i] = pdir_r[i] ? pdat_r[i] : gp_sync_r[i];
					end
					dat_nxt[TX_BIT] = tx_sync_r;
					dat_nxt[RX_BIT] = rx_sync_r;
				end
				IDX_PDIR: begin
					dat_nxt[7:2] = pdir_r;
				end
				default: begin
					// Filter words were filled in above; unmapped words read zero
				end
			endcase
		end
	end

	// State registers
	// Synchronous reset; all outputs start idle and the pins undriven
	// Everything runs every clock: there is no clock enable
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			for (int k = 0; k < 8; k++) begin
				code_r[k] <= CODE_RST;
				mask_r[k] <= MASK_RST;
			end
			srst_r          <= SRST_RST;
			org_r           <= CIDF_ORG_32;
			// No filter has hit yet
			hit_idx_r       <= 3'h0;
			pctl_r          <= PCTL_RST;
			pdat_r          <= PDAT_RST[7:2];
			pdir_r          <= PDIR_RST[7:2];
			port_pin_oe_n_o <= 6'h3F;
			wb_ack_o        <= 1'b0;
			wb_dat_o        <= '0;
			acc_o           <= '0;
		end else begin
			code_r          <= code_nxt;
			mask_r          <= mask_nxt;
			srst_r          <= srst_nxt;
			org_r           <= org_nxt;
			hit_idx_r       <= hit_idx_nxt;
			pctl_r          <= pctl_nxt;
			pdat_r          <= pdat_nxt;
			pdir_r          <= pdir_nxt;
			port_pin_oe_n_o <= oe_n_nxt;
			wb_ack_o        <= ack_nxt;
			wb_dat_o        <= dat_nxt;
			acc_o           <= acc_nxt;
		end
	end

	// Pin controls straight from flops; they act on pins 7..2 only
	// Pins 1 and 0 belong to the link and are never driven from here
	// Pull-up and drive strength act on the whole port together, so a
	// user cannot set them per pin
	assign port_pin_o           = pdat_r;
	assign port_pullup_enable_o = pctl_r[PUP_BIT];
	assign port_reduced_drive_o = pctl_r[RDP_BIT];

endmodule // cidf_top

//--- dv/cidf_top_asserts.sv
// Port checker for bus timing, verdicts and pin settings
`timescale 1ns/10ps
module cidf_top_asserts (
	// Clock and reset
	input wire logic                   sys_clk_i,
	input wire logic                   reset_i,
	// Bus, message, verdict and pins
	input wire cidf_pkg::cidf_wb_req_s wb_req_i,
	input wire logic                   wb_ack_o,
	input wire logic [cidf_pkg::WB_DW-1:0] wb_dat_o,
	input wire cidf_pkg::cidf_msg_s    msg_i,
	input wire cidf_pkg::cidf_acc_s    acc_o,
	input wire logic [7:2]             port_pin_oe_n_o,
	input wire logic                   port_pullup_enable_o
);
	// One clock domain, so one default clock and disable
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_after_take: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == '0)
		else $error("read data outside ack");
	a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_acc_from_msg: assert property (acc_o.valid |-> $past(msg_i.valid))
		else $error("verdict without message");
	a_dir_reset_in: assert property ($past(reset_i) |-> port_pin_oe_n_o == 6'h3F)
		else $error("pin driven after reset");
	a_pull_by_write: assert property ($changed(port_pullup_enable_o) |->
		$past(wb_req_i.cyc && wb_req_i.stb && wb_req_i.we)) else $error("pull changed alone");
	a_oe_by_write: assert property ($changed(port_pin_oe_n_o) |->
		$past(wb_req_i.cyc && wb_req_i.stb && wb_req_i.we)) else $error("enable changed alone");
endmodule // cidf_top_asserts

bind cidf_top cidf_top_asserts i_cidf_top_asserts (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
	.wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .msg_i(msg_i),
	.acc_o(acc_o), .port_pin_oe_n_o(port_pin_oe_n_o),
	.port_pullup_enable_o(port_pullup_enable_o));

//--- dv/cidf_pin_model.sv
// Board side of the port pins: outside drivers, pull-ups, floating lines
`timescale 1ns/10ps
module cidf_pin_model (
	// Clock for the floating pattern
	input wire logic       sys_clk_i,
	// Block side and outside drivers
	input wire logic [7:2] pin_out_i,
	input wire logic [7:2] pin_oe_n_i,
	input wire logic [7:2] ext_drv_i,
	input wire logic [7:2] ext_en_i,
	input wire logic       pullup_i,
	output logic [7:2]     pin_level_o
);
	logic flt_r = 1'b0; // Toggles so a floating pin never reads a fixed value
	always @(posedge sys_clk_i) flt_r <= ~flt_r;
	// Block drives when enable is low, else outside, pull-up, or noise
	always_comb begin
		for (int i = 2; i < 8; i++)
			pin_level_o[i] = !pin_oe_n_i[i] ? pin_out_i[i] : ext_en_i[i] ? ext_drv_i[i] :
				pullup_i ? 1'b1 : flt_r;
	end
endmodule // cidf_pin_model

//--- dv/tb_cidf_top.sv
// Self-checking bench for the identifier filter and port pins
`timescale 1ns/10ps
module tb_cidf_top;
	import cidf_pkg::*;
	logic sys_clk_i = 1'b0, reset_i = 1'b1, tx_r = 1'b0, rx_r = 1'b0, pup, rdp;
	cidf_wb_req_s wb_req_i = '0; // Bus request
	cidf_msg_s msg_i = '0; // Message identifier
	cidf_acc_s acc_o;
	logic wb_ack_o;
	logic [31:0] wb_dat_o;
	logic [7:2] pin_i, pin_o, oe_n, drv = '0, drv_en = '0;
	logic [7:0] code [8], mask [8]; // Filter contents written
	int mismatches = 0, samples_checked = 0, cyc_cnt = 0;
	cidf_top i_cidf_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .wb_req_i(wb_req_i),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .msg_i(msg_i), .acc_o(acc_o),
		.link_transmit_pin_i(tx_r), .link_receive_pin_i(rx_r), .port_pin_i(pin_i),
		.port_pin_o(pin_o), .port_pin_oe_n_o(oe_n), .port_pullup_enable_o(pup),
		.port_reduced_drive_o(rdp));
	cidf_pin_model i_cidf_pin_model (.sys_clk_i(sys_clk_i), .pin_out_i(pin_o), .pin_oe_n_i(oe_n),
		.ext_drv_i(drv), .ext_en_i(drv_en), .pullup_i(pup), .pin_level_o(pin_i));
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	// Hang guard
	always @(posedge sys_clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Classic cycle: hold until ack is seen, then release for a cycle
	task wb(input logic we, input logic [9:0] ix, input logic [7:0] d, output logic [31:0] q);
		@(posedge sys_clk_i) wb_req_i <= '{1'b1, 1'b1, we, {ix, 2'b00}, 4'hF, {24'h0, d}};
		// Ack and data are read at the edge, before that edge updates them
		do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_req_i <= '0;
	endtask
	task rd_chk(input logic [9:0] ix, input logic [7:0] e);
		logic [31:0] q;
		wb(1'b0, ix, 8'h00, q);
		chk(q, {24'h0, e});
	endtask
	// Expected {hit, lowest filter}; stride is bytes per filter
	function automatic logic [3:0] exp_acc(input logic [1:0] m, input logic e,
		input logic [3:0][7:0] id);
		int nf, nb, s;
		logic ok;
		exp_acc = 4'h0;
		nf = (m == 2'h0) ? 2 : (m == 2'h1) ? 4 : (m == 2'h2) ? 8 : 0;
		nb = (m == 2'h0) ? (e ? 4 : 2) : (m == 2'h1) ? 2 : 1;
		s = (nf == 0) ? 1 : 8 / nf;
		for (int f = nf - 1; f >= 0; f--) begin
			ok = 1'b1;
			for (int b = 0; b < nb; b++)
				if (((code[f*s+b] ^ id[b]) & ~mask[f*s+b]) != 8'h00) ok = 1'b0;
			if (ok) exp_acc = {1'b1, 3'(f)};
		end
	endfunction
	initial begin
		logic [31:0] q;
		logic [7:2] dir, lat;
		logic [3:0][7:0] id;
		logic e;
		logic [3:0] x;
		logic [2:0] lh;
		int s, j;
		void'($urandom(32'h5d719cd7));
		lh = 3'h0;
		repeat (5) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd_chk(IDX_PCTL, PCTL_RST);
		rd_chk(IDX_PDIR, PDIR_RST);
		chk({26'h0, oe_n}, 32'h3F);
		rd_chk(10'h3FF, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, IDX_CTL0, 8'h01, q);
			wb(1'b1, IDX_MODE, {2'b00, 2'(k), 4'h0}, q);
			for (int i = 0; i < 8; i++) begin
				code[i] = 8'($urandom);
				mask[i] = 8'($urandom | $urandom);
				if ((k == 0 && i % 4 == 1) || (k == 1 && i % 2 == 1))
					mask[i] = mask[i] | 8'h07;
				wb(1'b1, IDX_CODE[i], code[i], q);
				wb(1'b1, IDX_MASK[i], mask[i], q);
			end
			rd_chk(IDX_CODE[k], code[k]);
			wb(1'b1, IDX_CTL0, 8'h00, q);
			wb(1'b1, IDX_MASK[k], ~mask[k], q);
			rd_chk(IDX_MASK[k], mask[k]);
			s = (k == 0) ? 4 : (k == 1) ? 2 : 1;
			for (int n = 0; n < 40; n++) begin
				e = 1'($urandom);
				j = $urandom % (8 / s);
				for (int b = 0; b < 4; b++)
					id[b] = code[(j*s+b)%8] ^ 8'($urandom & $urandom & $urandom);
				@(posedge sys_clk_i) msg_i <= '{1'b1, e, id};
				@(posedge sys_clk_i) msg_i.valid <= 1'b0;
				x = exp_acc(2'(k), e, id);
				if (x[3]) lh = x[2:0];
				#1 chk({27'h0, acc_o.valid, acc_o.hit, acc_o.hit ? acc_o.idx : 3'h0},
					{27'h0, 1'b1, x});
			end
			rd_chk(IDX_MODE, {2'b00, 2'(k), 1'b0, lh});
		end
		wb(1'b1, IDX_PCTL, 8'h03, q);
		chk({30'h0, pup, rdp}, 32'h3);
		repeat (6) begin
			dir = 6'($urandom);
			lat = 6'($urandom);
			@(posedge sys_clk_i) begin
				drv_en <= ~dir;
				drv <= 6'($urandom);
				tx_r <= 1'($urandom);
				rx_r <= 1'($urandom);
			end
			wb(1'b1, IDX_PDIR, {dir, 2'b00}, q);
			wb(1'b1, IDX_PDAT, {lat, ~tx_r, ~rx_r}, q);
			chk({26'h0, pin_o}, {26'h0, lat});
			chk({26'h0, oe_n}, {26'h0, ~dir});
			rd_chk(IDX_PDAT, {(dir & lat) | (~dir & drv), tx_r, rx_r});
		end
		end_sim();
	end
endmodule // tb_cidf_top
